// ===== hw/ect_pkg.sv
// Constants and types of the edge capture and interval timer.
// Assumes a single 250 MHz clock that also serves as the capture time base.
//
// What this block does
// - A 16-bit free-running counter is the time base sampled by every capture.
// - Input A rising edge loads channel-0 rising register with selected counter bits.
// - Wide mode: channel-1 rising holds counter bits 15:8 from channel-0 rise.
// - Input A falling edge loads channel-0 falling; wide mode stores bits 7:0.
// - 8-bit mode: input B falling edge loads channel-1 falling register.
// - Wide mode: channel-1 falling holds counter bits 15:8 from channel-0 fall.
// - Prescale field, config bits 6:4, value n captures counter bits n+7:n in 8-bit mode.
// - Config bit 3 sets wide mode; input B ignored, channel 1 extends channel 0.
// - First-edge bit clear: every qualifying edge overwrites its capture register.
// - First-edge bit set: each register keeps first edge until software reads it.
// - Four interrupt enable bits, one per capture register; bits 7:4 reserved.
// - Status flags bits 0..3 mark A rise, A fall, B rise, B fall; in wide mode bits 2..3 mark A rise, A fall.
// - Writing one clears a status flag, zero leaves it; clear before next interrupt.
// - Reading interval count low byte snapshots its upper nibble.
// - Interval count high returns the nibble held at the last low-byte read.
// - Reload is a low byte plus high nibble, written low byte first.
// - A loaded, enabled capture raises its channel request; two channel requests.
// ***************************************************************************
package ect_pkg;

  // ***************************************************************************
  // Register indices; byte address is four times the index
  // ***************************************************************************
  localparam logic [7:0] IDX_CAP0_RISE  = 8'h22;
  localparam logic [7:0] IDX_CAP1_RISE  = 8'h23;
  localparam logic [7:0] IDX_CAP0_FALL  = 8'h24;
  localparam logic [7:0] IDX_CAP1_FALL  = 8'h25;
  localparam logic [7:0] IDX_PIT_LOW    = 8'h26;
  localparam logic [7:0] IDX_PIT_HIGH   = 8'h27;
  localparam logic [7:0] IDX_RELOAD_LOW = 8'h28;
  localparam logic [7:0] IDX_RELOAD_HI  = 8'h29;
  localparam logic [7:0] IDX_CONFIG     = 8'h2a;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h2b;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h2c;
  localparam logic [7:0] IDX_PIT_STATUS = 8'h2d;

  // ***************************************************************************
  // Field positions and reset values
  // ***************************************************************************
  localparam int         PIT_FLAG_BIT   = 0;
  localparam int         PIT_EN_BIT     = 1;
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [3:0] RST_NIBBLE     = 4'h0;
  localparam logic [2:0] HSIZE_WORD     = 3'h2;

  typedef struct packed {
    logic       first_hold;
    logic [2:0] prescale;
    logic       wide_capture_enable;
    logic [2:0] reserved;
  } ect_cfg_type;

endpackage

// ===== hw/ect_capture_timer.sv
// Edge capture and interval timer with its AHB-Lite register slave.
// Assumes one bus master, capture inputs synchronous-safe after two flops.
`timescale 1ns/1ps
module ect_capture_timer #(
  parameter int ADDR_W = 12,
  parameter int PIT_W  = 12
) (
  // Clock and reset
  input  wire logic              MCLK,
  input  wire logic              RST_N,
  // AHB-Lite slave
  input  wire logic              HSEL,
  input  wire logic [ADDR_W-1:0] HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic      [31:0]       HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  // Capture pins
  input  wire logic              CAPTURE_INPUT_A,
  input  wire logic              CAPTURE_INPUT_B,
  // Interrupt requests
  output logic                   IRQ,
  output logic                   CAP0_IRQ,
  output logic                   CAP1_IRQ
);
  import ect_pkg::*;

  // ***************************************************************************
  // Helpers
  // ***************************************************************************
  function automatic logic [7:0] window(input logic [15:0] c, input logic [2:0] p);
    window = 8'(c >> p);
  endfunction

  function automatic logic [7:0] cap_index(input int i);
    unique case (i)
      0:       cap_index = IDX_CAP0_RISE;
      1:       cap_index = IDX_CAP0_FALL;
      2:       cap_index = IDX_CAP1_RISE;
      default: cap_index = IDX_CAP1_FALL;
    endcase
  endfunction

  // ***************************************************************************
  // Input synchronisers and edge detect
  // ***************************************************************************
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] prev;
  logic [1:0] next_sync1;
  logic [1:0] next_sync2;
  logic [1:0] next_prev;
  logic [1:0] rise;
  logic [1:0] fall;

  always_comb begin
    next_sync1 = {CAPTURE_INPUT_B, CAPTURE_INPUT_A};
    next_sync2 = sync1;
    next_prev  = sync2;
    rise       = sync2 & ~prev;
    fall       = ~sync2 & prev;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
      prev  <= 2'h0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev  <= next_prev;
    end
  end

  // ***************************************************************************
  // Bus slave: one wait state so read data leaves a flop
  // ***************************************************************************
  logic       pend;
  logic       wr_q;
  logic       ok_q;
  logic [7:0] idx_q;
  logic       next_pend;
  logic       next_wr;
  logic       next_ok;
  logic [7:0] next_idx;
  logic [31:0] next_rdata;
  logic       next_ready;
  logic       acc;
  logic       dwr;
  logic       drd;
  logic [7:0] wdat;
  logic [7:0] rd_val;

  always_comb begin
    acc        = HSEL && HTRANS[1] && HREADY;
    next_pend  = acc;
    next_ready = !acc;
    next_wr    = acc ? HWRITE : wr_q;
    next_idx   = acc ? HADDR[9:2] : idx_q;
    next_ok    = acc ? (HADDR[1:0] == 2'h0 && HSIZE == HSIZE_WORD
                        && (HADDR >> 10) == '0) : ok_q;
    dwr        = pend && wr_q && ok_q;
    drd        = pend && !wr_q && ok_q;
    wdat       = HWDATA[7:0];
    next_rdata = pend ? {24'h0, (drd ? rd_val : 8'h00)} : HRDATA;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      pend      <= 1'b0;
      wr_q      <= 1'b0;
      ok_q      <= 1'b0;
      idx_q     <= 8'h00;
      HRDATA    <= 32'h0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      pend      <= next_pend;
      wr_q      <= next_wr;
      ok_q      <= next_ok;
      idx_q     <= next_idx;
      HRDATA    <= next_rdata;
      HREADYOUT <= next_ready;
      HRESP     <= 1'b0;
    end
  end

  // ***************************************************************************
  // Capture, interval timer and interrupt state
  // ***************************************************************************
  logic [15:0]      frc;
  logic [7:0]       cap [4];
  logic [3:0]       held;
  logic [3:0]       status;
  logic [3:0]       irq_en;
  ect_cfg_type      cfg;
  logic [PIT_W-1:0] pit;
  logic [PIT_W-1:0] reload;
  logic [3:0]       pit_hold;
  logic             pit_flag;
  logic             pit_en;

  logic [15:0]      next_frc;
  logic [7:0]       next_cap [4];
  logic [3:0]       next_held;
  logic [3:0]       next_status;
  logic [3:0]       next_irq_en;
  ect_cfg_type      next_cfg;
  logic [PIT_W-1:0] next_pit;
  logic [PIT_W-1:0] next_reload;
  logic [3:0]       next_pit_hold;
  logic             next_pit_flag;
  logic             next_pit_en;
  logic             next_irq;
  logic             next_cap0_irq;
  logic             next_cap1_irq;
  logic [3:0]       edge_hit;
  logic [3:0]       ld;
  logic [7:0]       sel8;
  logic [3:0]       rd_cap;
  logic             pit_tc;

  always_comb begin
    next_frc = frc + 16'h1;
    sel8     = window(frc, cfg.prescale);
    if (cfg.wide_capture_enable) begin
      // Input B is not looked at in wide mode
      edge_hit = {fall[0], rise[0], fall[0], rise[0]};
    end else begin
      edge_hit = {fall[1], rise[1], fall[0], rise[0]};
    end
    for (int i = 0; i < 4; i++) begin
      rd_cap[i]   = drd && idx_q == cap_index(i);
      ld[i]       = edge_hit[i] && !(cfg.first_hold && held[i]);
      next_cap[i] = cap[i];
      if (dwr && idx_q == cap_index(i)) begin
        next_cap[i] = wdat;
      end
      if (ld[i]) begin
        if (!cfg.wide_capture_enable) begin
          next_cap[i] = sel8;
        end else if (i < 2) begin
          next_cap[i] = frc[7:0];
        end else begin
          next_cap[i] = frc[15:8];
        end
      end
    end
    // Read releases the hold; an edge in the same cycle is still ignored
    next_held = cfg.first_hold ? ((held & ~rd_cap) | ld) : 4'h0;

    // Set beats clear so an edge in the clearing cycle is kept
    next_status = status | ld;
    if (dwr && idx_q == IDX_IRQ_STATUS) begin
      next_status = (status & ~wdat[3:0]) | ld;
    end

    next_cfg    = cfg;
    next_irq_en = irq_en;
    next_reload = reload;
    next_pit_en = pit_en;
    if (dwr) begin
      unique case (idx_q)
        IDX_CONFIG:     next_cfg = {wdat[7:3], 3'h0};
        IDX_IRQ_ENABLE: next_irq_en = wdat[3:0];
        IDX_RELOAD_LOW: next_reload = {reload[PIT_W-1:8], wdat};
        IDX_RELOAD_HI:  next_reload = {wdat[PIT_W-9:0], reload[7:0]};
        IDX_PIT_STATUS: next_pit_en = wdat[PIT_EN_BIT];
        default:        next_pit_en = pit_en;
      endcase
    end

    // A zero reload parks the timer instead of flagging every cycle
    pit_tc   = pit == '0 && reload != '0;
    next_pit = pit_tc ? reload : (pit == '0 ? pit : pit - 1'b1);
    next_pit_flag = pit_flag | pit_tc;
    if (dwr && idx_q == IDX_PIT_STATUS) begin
      next_pit_flag = (pit_flag & ~wdat[PIT_FLAG_BIT]) | pit_tc;
    end
    next_pit_hold = pit_hold;
    if (drd && idx_q == IDX_PIT_LOW) begin
      next_pit_hold = pit[PIT_W-1:8];
    end

    next_cap0_irq = |(status[1:0] & irq_en[1:0]);
    next_cap1_irq = |(status[3:2] & irq_en[3:2]);
    next_irq      = next_cap0_irq || next_cap1_irq || (pit_flag && pit_en);

    unique case (idx_q)
      IDX_CAP0_RISE:  rd_val = cap[0];
      IDX_CAP0_FALL:  rd_val = cap[1];
      IDX_CAP1_RISE:  rd_val = cap[2];
      IDX_CAP1_FALL:  rd_val = cap[3];
      IDX_PIT_LOW:    rd_val = pit[7:0];
      IDX_PIT_HIGH:   rd_val = {4'h0, pit_hold};
      IDX_RELOAD_LOW: rd_val = reload[7:0];
      IDX_RELOAD_HI:  rd_val = {4'h0, reload[PIT_W-1:8]};
      IDX_CONFIG:     rd_val = cfg;
      IDX_IRQ_ENABLE: rd_val = {4'h0, irq_en};
      IDX_IRQ_STATUS: rd_val = {4'h0, status};
      IDX_PIT_STATUS: rd_val = {6'h0, pit_en, pit_flag};
      default:        rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      frc      <= 16'h0;
      for (int i = 0; i < 4; i++) begin
        cap[i] <= RST_BYTE;
      end
      held     <= 4'h0;
      status   <= RST_NIBBLE;
      irq_en   <= RST_NIBBLE;
      cfg      <= RST_BYTE;
      pit      <= '0;
      reload   <= '0;
      pit_hold <= RST_NIBBLE;
      pit_flag <= 1'b0;
      pit_en   <= 1'b0;
      IRQ      <= 1'b0;
      CAP0_IRQ <= 1'b0;
      CAP1_IRQ <= 1'b0;
    end else begin
      frc      <= next_frc;
      cap      <= next_cap;
      held     <= next_held;
      status   <= next_status;
      irq_en   <= next_irq_en;
      cfg      <= next_cfg;
      pit      <= next_pit;
      reload   <= next_reload;
      pit_hold <= next_pit_hold;
      pit_flag <= next_pit_flag;
      pit_en   <= next_pit_en;
      IRQ      <= next_irq;
      CAP0_IRQ <= next_cap0_irq;
      CAP1_IRQ <= next_cap1_irq;
    end
  end

  // ***************************************************************************
  // Assertions
  // ***************************************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  // Gated on a sampled reset so the release edge is not mistaken for a stall
  property p_frc_runs;
    RST_N |=> frc == $past(frc) + 16'h1;
  endproperty
  a_frc_runs: assert property (p_frc_runs) else $error("time base stalled");

  property p_rise0_8bit;
    rise[0] && !cfg.wide_capture_enable && !(cfg.first_hold && held[0])
      |=> cap[0] == window($past(frc), $past(cfg.prescale));
  endproperty
  a_rise0_8bit: assert property (p_rise0_8bit) else $error("bad rise capture");

  property p_wide_rise;
    rise[0] && cfg.wide_capture_enable && !cfg.first_hold
      |=> cap[2] == $past(frc[15:8]) && cap[0] == $past(frc[7:0]);
  endproperty
  a_wide_rise: assert property (p_wide_rise) else $error("bad wide rise");

  property p_wide_fall;
    fall[0] && cfg.wide_capture_enable && !cfg.first_hold
      |=> cap[3] == $past(frc[15:8]) && cap[1] == $past(frc[7:0]);
  endproperty
  a_wide_fall: assert property (p_wide_fall) else $error("bad wide fall");

  property p_fall1_8bit;
    fall[1] && !cfg.wide_capture_enable && !cfg.first_hold
      |=> cap[3] == window($past(frc), $past(cfg.prescale));
  endproperty
  a_fall1_8bit: assert property (p_fall1_8bit) else $error("bad B fall");

  property p_wide_ignores_b;
    cfg.wide_capture_enable && !rise[0] && !dwr |=> $stable(cap[2]);
  endproperty
  a_wide_ignores_b: assert property (p_wide_ignores_b) else $error("B captured");

  property p_hold_keeps;
    cfg.first_hold && held[0] && !rd_cap[0] && !dwr |=> $stable(cap[0]);
  endproperty
  a_hold_keeps: assert property (p_hold_keeps) else $error("held value lost");

  sequence s_w1c_status;
    dwr && idx_q == IDX_IRQ_STATUS && wdat[0] && !ld[0];
  endsequence
  property p_w1c;
    s_w1c_status |=> !status[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");

  property p_w0_keeps;
    dwr && idx_q == IDX_IRQ_STATUS && !wdat[0] && status[0] |=> status[0];
  endproperty
  a_w0_keeps: assert property (p_w0_keeps) else $error("flag lost on zero write");

  property p_set_wins;
    ld[0] |=> status[0] and (irq_en[0] |=> CAP0_IRQ);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag or request lost");

  property p_pit_snap;
    drd && idx_q == IDX_PIT_LOW |=> pit_hold == $past(pit[PIT_W-1:8]);
  endproperty
  a_pit_snap: assert property (p_pit_snap) else $error("nibble not held");

  property p_pit_high_read;
    drd && idx_q == IDX_PIT_HIGH |=> HRDATA == {28'h0, $past(pit_hold)};
  endproperty
  a_pit_high_read: assert property (p_pit_high_read) else $error("nibble read wrong");

  property p_pit_reload;
    pit_tc |=> pit == $past(reload) && pit_flag;
  endproperty
  a_pit_reload: assert property (p_pit_reload) else $error("no reload");

  sequence s_wait_state;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  property p_bus_answer;
    acc |=> s_wait_state;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

endmodule

// ===== tb/tb_ect_capture_timer.sv
// Self-checking bench for the edge capture and interval timer.
// Assumes the AHB-Lite slave answers with one wait state and HREADY tied to HREADYOUT.
`timescale 1ns/1ps
module tb_ect_capture_timer;
  import ect_pkg::*;
  // ***************************************************************************
  // Signals
  // ***************************************************************************
  logic        MCLK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP;
  logic        CAPTURE_INPUT_A, CAPTURE_INPUT_B, IRQ, CAP0_IRQ, CAP1_IRQ;
  logic [11:0] HADDR;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [31:0] HWDATA, HRDATA, rdat;
  logic [32:0] exp_q[$];
  logic        rd_ph;
  logic [15:0] vref;
  logic [11:0] v1, v2;
  int          fail_count, n_tests, seed, cyc, t_acc, tp, tr, tf, tref, t1;

  ect_capture_timer dut (
    .MCLK(MCLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .CAPTURE_INPUT_A(CAPTURE_INPUT_A), .CAPTURE_INPUT_B(CAPTURE_INPUT_B),
    .IRQ(IRQ), .CAP0_IRQ(CAP0_IRQ), .CAP1_IRQ(CAP1_IRQ)
  );

  always #2 MCLK = ~MCLK;
  always @(posedge MCLK) cyc <= cyc + 1;

  // ***************************************************************************
  // Checking and closing
  // ***************************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Read results are compared here, oldest note first
  always @(posedge MCLK) begin
    if (rd_ph && HREADYOUT === 1'b1 && exp_q.size() > 0) begin
      if (exp_q[0][32]) check(HRDATA, exp_q[0][31:0]);
      void'(exp_q.pop_front());
    end
    if (HSEL && HTRANS[1] && HREADYOUT) rd_ph <= !HWRITE;
    else if (HREADYOUT) rd_ph <= 1'b0;
  end

  initial begin
    repeat (100000) @(posedge MCLK);
    fail_count++;
    stop_test();
  end

  // ***************************************************************************
  // Bus and pin drivers
  // ***************************************************************************
  task automatic wait_ready;
    int i;
    i = 0;
    do begin
      @(posedge MCLK);
      i++;
      if (i > 50) begin
        fail_count++;
        stop_test();
      end
    end while (HREADYOUT !== 1'b1);
  endtask

  task automatic xfer(input logic [7:0] idx, input logic w, input logic [31:0] d);
    HSEL   <= 1'b1;
    HTRANS <= 2'b10;
    HADDR  <= {2'b00, idx, 2'b00};
    HWRITE <= w;
    wait_ready();
    t_acc = cyc;
    HSEL   <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    wait_ready();
    rdat = HRDATA;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(idx, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    exp_q.push_back({1'b1, e});
    xfer(idx, 1'b0, 32'h0);
  endtask

  // Reference read: value kept, not compared
  task automatic rr(input logic [7:0] idx);
    exp_q.push_back({1'b0, 32'h0});
    xfer(idx, 1'b0, 32'h0);
  endtask

  task automatic pin(input logic a, input logic b);
    CAPTURE_INPUT_A <= a;
    CAPTURE_INPUT_B <= b;
    tp = cyc;
    @(posedge MCLK);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge MCLK);
  endtask

  // Window of the time base at bench cycle t, relative to the wide reference
  function automatic logic [31:0] ex(input int t, input int n);
    logic [15:0] s;
    s = vref + 16'(t - tref);
    return {24'h0, 8'(s >> n)};
  endfunction

  // ***************************************************************************
  // Scenarios
  // ***************************************************************************
  initial begin
    MCLK = 1'b0; RST_N = 1'b0; HSEL = 1'b0; HWRITE = 1'b0; HADDR = 12'h0;
    HTRANS = 2'b00; HSIZE = HSIZE_WORD; HWDATA = 32'h0; rd_ph = 1'b0;
    CAPTURE_INPUT_A = 1'b0; CAPTURE_INPUT_B = 1'b0; cyc = 0; seed = 32'h5222;
    fail_count = 0; n_tests = 0;
    idle(12);
    RST_N <= 1'b1;
    idle(1);
    for (int i = 8'h22; i <= 8'h2d; i++) rd(8'(i), 32'h0);
    wr(8'h30, 32'hff);
    rd(8'h30, 32'h0);
    // Reserved bits drop, writable ones hold
    wr(IDX_CONFIG, 32'hff);
    rd(IDX_CONFIG, 32'hf8);
    wr(IDX_IRQ_ENABLE, 32'hff);
    rd(IDX_IRQ_ENABLE, 32'h0f);
    wr(IDX_RELOAD_LOW, 32'h00);
    wr(IDX_RELOAD_HI, 32'hff);
    rd(IDX_RELOAD_HI, 32'h0f);
    v1 = 12'($random(seed));
    wr(IDX_CAP1_FALL, {24'h0, v1[7:0]});
    rd(IDX_CAP1_FALL, {24'h0, v1[7:0]});
    // Wide mode: one 16-bit capture, input B ignored
    wr(IDX_CONFIG, 32'h08);
    wr(IDX_IRQ_ENABLE, 32'h01);
    pin(1'b1, 1'b1);
    tr = tp;
    idle(20 + ($random(seed) & 255));
    pin(1'b0, 1'b1);
    tf = tp;
    idle(10);
    check(32'(CAP0_IRQ), 32'h1);
    check(32'(CAP1_IRQ), 32'h0);
    check(32'(IRQ), 32'h1);
    rr(IDX_CAP0_RISE);
    vref[7:0] = rdat[7:0];
    rr(IDX_CAP1_RISE);
    vref[15:8] = rdat[7:0];
    tref = tr;
    rd(IDX_CAP0_FALL, ex(tf, 0));
    rd(IDX_CAP1_FALL, ex(tf, 8));
    rd(IDX_IRQ_STATUS, 32'h0f);
    wr(IDX_IRQ_STATUS, 32'h01);
    rd(IDX_IRQ_STATUS, 32'h0e);
    check(32'(CAP0_IRQ), 32'h0);
    check(32'(IRQ), 32'h0);
    wr(IDX_IRQ_STATUS, 32'h00);
    rd(IDX_IRQ_STATUS, 32'h0e);
    wr(IDX_IRQ_STATUS, 32'h0f);
    pin(1'b0, 1'b0);
    idle(8);
    rd(IDX_IRQ_STATUS, 32'h00);
    // Eight-bit mode, every prescale window, both inputs
    wr(IDX_IRQ_ENABLE, 32'h0c);
    for (int n = 0; n < 8; n++) begin
      wr(IDX_CONFIG, 32'(n << 4));
      pin(1'b1, 1'b1);
      tr = tp;
      idle(3 + ($random(seed) & 63));
      pin(1'b0, 1'b0);
      tf = tp;
      idle(8);
      rd(IDX_CAP0_RISE, ex(tr, n));
      rd(IDX_CAP1_RISE, ex(tr, n));
      rd(IDX_CAP0_FALL, ex(tf, n));
      rd(IDX_CAP1_FALL, ex(tf, n));
    end
    rd(IDX_IRQ_STATUS, 32'h0f);
    check(32'(CAP1_IRQ), 32'h1);
    check(32'(CAP0_IRQ), 32'h0);
    // First-edge hold keeps the first time until read
    wr(IDX_IRQ_STATUS, 32'h0f);
    wr(IDX_CONFIG, 32'h80);
    pin(1'b1, 1'b0);
    tr = tp;
    idle(5);
    pin(1'b0, 1'b0);
    tf = tp;
    idle(5);
    pin(1'b1, 1'b0);
    idle(5);
    pin(1'b0, 1'b0);
    idle(8);
    rd(IDX_CAP0_RISE, ex(tr, 0));
    rd(IDX_CAP0_FALL, ex(tf, 0));
    pin(1'b1, 1'b0);
    tr = tp;
    idle(8);
    rd(IDX_CAP0_RISE, ex(tr, 0));
    pin(1'b0, 1'b0);
    // Interval count read as one coherent value
    wr(IDX_RELOAD_LOW, 32'hff);
    wr(IDX_RELOAD_HI, 32'h0f);
    rd(IDX_RELOAD_LOW, 32'hff);
    idle(5000);
    rr(IDX_PIT_LOW);
    v1[7:0] = rdat[7:0];
    t1 = t_acc;
    rr(IDX_PIT_HIGH);
    v1[11:8] = rdat[3:0];
    // One step a cycle, wrapping through the full reload, so 12-bit math holds
    idle(20);
    v2 = v1 - 12'(cyc + 1 - t1);
    rd(IDX_PIT_LOW, {24'h0, v2[7:0]});
    idle(40 + ($random(seed) & 63));
    rd(IDX_PIT_HIGH, {28'h0, v2[11:8]});
    // Zero reload parks the timer, so its flag clears without a race
    wr(IDX_RELOAD_LOW, 32'h00);
    wr(IDX_RELOAD_HI, 32'h00);
    idle(4200);
    rd(IDX_PIT_LOW, 32'h0);
    rd(IDX_PIT_STATUS, 32'h01);
    wr(IDX_PIT_STATUS, 32'h02);
    idle(1);
    check(32'(IRQ), 32'h1);
    wr(IDX_PIT_STATUS, 32'h03);
    idle(1);
    check(32'(IRQ), 32'h0);
    rd(IDX_PIT_STATUS, 32'h02);
    stop_test();
  end
endmodule
